/* logic/cbd_map.svh */
// constants and field positions of the configuration bit command port
`ifndef CBD_MAP_SVH
`define CBD_MAP_SVH
// Functional notes
// - start a nonvolatile write only after a complete, well-formed frame
// - during a write cycle accept only volatile commands; enable/disable commands raise the error, the rest are ignored
// - volatile output, reference, power, gain and lock status stay usable
// - write-active flag shows a nonvolatile write cycle in progress
// - high-voltage pin level marks a command as high-voltage
// - only high-voltage commands may change the lock configuration bits
// - frame: five address bits msb first, code 01, then error bit slot
// - after an error slot is low, all later output bits stay low
// - errored command is not completed; only chip select clears error
// - reference select 00 picks the supply as ladder reference
// - stored settings are recalled at each power-up
// - set lock bits block changes to stored output values
// - enable command uses the same frame with code 10
// header slot where the frame is judged, last slot of short and long frames
`define HDR_LAST 5'h06
`define SHORT_LAST 5'h07
`define LONG_LAST 5'h17
// field positions inside the seven header bits
`define ADDR_MSB 6
`define ADDR_LSB 2
`define CODE_MSB 1
`define CODE_LSB 0
// address ranges
`define VOLATILE_LAST 5'h0F
`define CFG_FIRST 5'h10
`define CFG_LAST 5'h11
// reference field code that selects the supply
`define REF_SUPPLY 2'h0
// reset values
`define LOCK_RESET 2'h0
`define SDO_IDLE 1'b1
// timing
`define CLOCK_PERIOD_NS 10
`define NV_WRITE_TIME_NS 5000000
`endif

/* logic/cbd_pkg.sv */
// types of the configuration bit command port
`default_nettype none
package cbd_pkg;
   // command code bits of a frame header
   typedef enum logic [1:0] {
      CMD_WRITE = 2'h0,
      CMD_DISABLE = 2'h1,
      CMD_ENABLE = 2'h2,
      CMD_READ = 2'h3
   } cmd_code_t;
   // register address bits of a frame header
   typedef logic [4:0] reg_addr_t;
   // states of the write-cycle machine
   typedef enum logic [2:0] {
      ST_RECALL = 3'b001,
      ST_IDLE = 3'b010,
      ST_WRITE = 3'b100
   } cycle_state_t;
endpackage : cbd_pkg
`default_nettype wire

/* logic/sync_two_flop.sv */
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop
(
   input wire logic clock,
   input wire logic reset,
   input wire logic level,
   output logic synced
);
   logic stage;
   // first stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stage <= 1'b0;
         synced <= 1'b0;
      end
      else
      begin
         stage <= level;
         synced <= stage;
      end
   end
endmodule : sync_two_flop
`default_nettype wire

/* logic/nv_write_timer.sv */
// counts out one nonvolatile write cycle
`timescale 1ns/10ps
`default_nettype none
module nv_write_timer #(
   parameter int CYCLES = 500000
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   output logic done
);
   logic [23:0] count;
   // load on start, count down, pulse done on the last cycle
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         count <= 24'h000000;
         done <= 1'b0;
      end
      else if (start)
      begin
         count <= 24'(CYCLES);
         done <= 1'b0;
      end
      else
      begin
         done <= (count == 24'h000001);
         if (count != 24'h000000)
            count <= count - 24'h000001;
      end
   end
endmodule : nv_write_timer
`default_nettype wire

/* logic/config_bit_disable_command.sv */
// serial command handling for the high-voltage configuration bit commands
`timescale 1ns/10ps
`default_nettype none
`include "cbd_map.svh"
module config_bit_disable_command #(
   parameter int NV_WRITE_CYCLES =
      (`NV_WRITE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic serialClock,
   input wire logic chipSelectN,
   input wire logic serialDataIn,
   input wire logic highVoltageCommandPin,
   input wire logic [1:0] storedLockBits,
   input wire logic [3:0] referenceSelectField,
   output logic serialDataOut,
   output logic serialDataOutEnable,
   output logic nvWriteActiveFlag,
   output logic nvWriteStrobe,
   output logic [4:0] nvWriteAddress,
   output logic nvWriteValue,
   output logic [1:0] lockBits,
   output logic [1:0] supplyReference,
   output logic volatileCommandStrobe,
   output logic [4:0] volatileCommandAddress,
   output logic [1:0] volatileCommandCode
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // true for the enable and disable codes
   function automatic logic isConfigCode(input logic [1:0] code);
      isConfigCode = (code == cbd_pkg::CMD_DISABLE) ||
                     (code == cbd_pkg::CMD_ENABLE);
   endfunction : isConfigCode

   // true for addresses that carry a lock bit
   function automatic logic isConfigAddress(input logic [4:0] addr);
      isConfigAddress = (addr >= `CFG_FIRST) && (addr <= `CFG_LAST);
   endfunction : isConfigAddress

   // true for addresses in volatile memory
   function automatic logic isVolatile(input logic [4:0] addr);
      isVolatile = (addr <= `VOLATILE_LAST);
   endfunction : isVolatile

   ////////////////////////////////////////////////////////////////////////
   // link side, clocked by the serial clock

   logic [4:0] bitCount;
   logic [5:0] headerShift;
   logic longFrame;
   logic errorFlag;
   logic frameRequest;
   logic [4:0] frameAddress;
   logic [1:0] frameCode;
   logic highVoltageLink;
   logic writeActiveLink;
   logic [6:0] header;
   cbd_pkg::reg_addr_t headerAddress;
   logic [1:0] headerCode;
   logic headerConfig;
   logic headerError;
   logic headerIgnored;
   logic atHeaderEnd;
   logic atFrameEnd;
   logic atRequestSlot;
   logic headerAccepted;

   // high-voltage pin level seen by the link logic
   // the serial clock stops between selects, so this holds the last level
   // until two edges of the new select have passed
   sync_two_flop highVoltageSync (
      .clock(serialClock),
      .reset(1'b0),
      .level(highVoltageCommandPin),
      .synced(highVoltageLink)
   );

   // write-active flag carried over to the link logic
   sync_two_flop writeActiveSync (
      .clock(serialClock),
      .reset(1'b0),
      .level(nvWriteActiveFlag),
      .synced(writeActiveLink)
   );

   // judge the header on its seventh bit
   always_comb
   begin
      header = {headerShift, serialDataIn};
      headerAddress = header[`ADDR_MSB:`ADDR_LSB];
      headerCode = header[`CODE_MSB:`CODE_LSB];
      headerConfig = isConfigCode(headerCode);
      headerError = headerConfig &&
                    (!highVoltageLink ||
                     writeActiveLink ||
                     !isConfigAddress(headerAddress));
      headerIgnored = !headerConfig && writeActiveLink &&
                      !isVolatile(headerAddress);
      atHeaderEnd = (bitCount == `HDR_LAST);
      atFrameEnd = longFrame ? (bitCount == `LONG_LAST)
                             : (bitCount == `SHORT_LAST);
      atRequestSlot = (bitCount == `SHORT_LAST);
   end

   // bit position inside the current frame, wraps for the next frame
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         bitCount <= 5'h00;
      else if (atFrameEnd)
         bitCount <= 5'h00;
      else
         bitCount <= bitCount + 5'h01;
   end

   // frame length chosen by the header code
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         longFrame <= 1'b0;
      else if (atHeaderEnd)
         longFrame <= !headerConfig;
      else if (atFrameEnd)
         longFrame <= 1'b0;
   end

   // serial data in, shifted msb first
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         headerShift <= 6'h00;
      else
         headerShift <= {headerShift[4:0], serialDataIn};
   end

   // sticky command error, cleared only by chip select release
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         errorFlag <= 1'b0;
      else if (atHeaderEnd && headerError)
         errorFlag <= 1'b1;
   end

   // header verdict kept until the eighth bit of the frame arrives
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         headerAccepted <= 1'b0;
      else if (atHeaderEnd)
         headerAccepted <= !errorFlag && !headerError &&
                           !headerIgnored;
   end

   // request to the system side, one serial period wide, raised only
   // once the eighth bit is in, so a cut frame never starts a write
   always_ff @(posedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
         frameRequest <= 1'b0;
      else
         frameRequest <= atRequestSlot && headerAccepted &&
                         !errorFlag;
   end

   // header fields, reloaded at every header end and read by the
   // system side only while a request of the same frame stands
   always_ff @(posedge serialClock)
   begin
      if (atHeaderEnd)
      begin
         frameAddress <= headerAddress;
         frameCode <= headerCode;
      end
   end

   // serial data out changes on the falling edge
   always_ff @(negedge serialClock or posedge chipSelectN)
   begin
      if (chipSelectN)
      begin
         serialDataOut <= `SDO_IDLE;
         serialDataOutEnable <= 1'b0;
      end
      else
      begin
         serialDataOut <= !errorFlag;
         serialDataOutEnable <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system side, clocked by clock

   cbd_pkg::cycle_state_t state;
   logic requestSync;
   logic requestSeen;
   logic newFrame;
   logic frameConfig;
   logic timerStart;
   logic timerDone;

   // frame request carried into the system clock
   // frameAddress and frameCode load a serial period before the request
   // rises and stay put until the next header ends, so they are settled
   sync_two_flop requestSyncer (
      .clock(clock),
      .reset(reset),
      .level(frameRequest),
      .synced(requestSync)
   );

   // edge of the synced request
   always_ff @(posedge clock)
   begin
      if (reset)
         requestSeen <= 1'b0;
      else
         requestSeen <= requestSync;
   end

   // new frame and its kind
   always_comb
   begin
      newFrame = requestSync && !requestSeen;
      frameConfig = isConfigCode(frameCode);
      timerStart = newFrame && frameConfig &&
                   (state == cbd_pkg::ST_IDLE);
   end

   // length of one nonvolatile write cycle
   nv_write_timer #(
      .CYCLES(NV_WRITE_CYCLES)
   ) writeTimer (
      .clock(clock),
      .reset(reset),
      .start(timerStart),
      .done(timerDone)
   );

   // recall, idle and write states
   always_ff @(posedge clock)
   begin
      if (reset)
         state <= cbd_pkg::ST_RECALL;
      else
      begin
         case (state)
            cbd_pkg::ST_RECALL:
               state <= cbd_pkg::ST_IDLE;
            cbd_pkg::ST_IDLE:
               if (timerStart)
                  state <= cbd_pkg::ST_WRITE;
            cbd_pkg::ST_WRITE:
               if (timerDone)
                  state <= cbd_pkg::ST_IDLE;
            default:
               state <= cbd_pkg::ST_IDLE;
         endcase
      end
   end

   // write-active flag follows the write state
   always_ff @(posedge clock)
   begin
      if (reset)
         nvWriteActiveFlag <= 1'b0;
      else if (timerStart)
         nvWriteActiveFlag <= 1'b1;
      else if (timerDone)
         nvWriteActiveFlag <= 1'b0;
   end

   // lock bits: recalled after reset, changed only by high-voltage frames
   always_ff @(posedge clock)
   begin
      if (reset)
         lockBits <= `LOCK_RESET;
      else if (state == cbd_pkg::ST_RECALL)
         lockBits <= storedLockBits;
      else if (timerStart)
         lockBits[frameAddress[0]] <=
            (frameCode == cbd_pkg::CMD_ENABLE);
   end

   // one-cycle store request towards the nonvolatile array
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         nvWriteStrobe <= 1'b0;
         nvWriteAddress <= 5'h00;
         nvWriteValue <= 1'b0;
      end
      else
      begin
         nvWriteStrobe <= timerStart;
         if (timerStart)
         begin
            nvWriteAddress <= frameAddress;
            nvWriteValue <= (frameCode == cbd_pkg::CMD_ENABLE);
         end
      end
   end

   // volatile commands pass on, also during a write cycle
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         volatileCommandStrobe <= 1'b0;
         volatileCommandAddress <= 5'h00;
         volatileCommandCode <= 2'h0;
      end
      else
      begin
         volatileCommandStrobe <= newFrame && !frameConfig &&
            (!nvWriteActiveFlag || isVolatile(frameAddress));
         if (newFrame && !frameConfig)
         begin
            volatileCommandAddress <= frameAddress;
            volatileCommandCode <= frameCode;
         end
      end
   end

   // supply chosen as ladder reference per channel
   always_ff @(posedge clock)
   begin
      if (reset)
         supplyReference <= 2'h0;
      else
      begin
         supplyReference[0] <=
            (referenceSelectField[1:0] == `REF_SUPPLY);
         supplyReference[1] <=
            (referenceSelectField[3:2] == `REF_SUPPLY);
      end
   end

endmodule : config_bit_disable_command
`default_nettype wire

/* verification/cbd_chk.sv */
// assertions on the ports of the configuration bit command port
`timescale 1ns/10ps
`default_nettype none
module cbd_chk #(
   parameter int NV_WRITE_CYCLES = 500000
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic chipSelectN,
   input wire logic [3:0] referenceSelectField,
   input wire logic serialDataOut,
   input wire logic serialDataOutEnable,
   input wire logic nvWriteActiveFlag,
   input wire logic nvWriteStrobe,
   input wire logic [4:0] nvWriteAddress,
   input wire logic nvWriteValue,
   input wire logic [1:0] lockBits,
   input wire logic [1:0] supplyReference,
   input wire logic volatileCommandStrobe,
   input wire logic [4:0] volatileCommandAddress,
   input wire logic [1:0] volatileCommandCode
);
   int busyCount;
   int age;
   // cycles with the flag high, and cycles since reset, held at 7
   always_ff @(posedge clock)
   begin
      busyCount <= nvWriteActiveFlag ? busyCount + 1 : 0;
      age <= reset ? 0 : (age < 7 ? age + 1 : age);
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   busy_rise_a: assert property ($rose(nvWriteActiveFlag) |-> nvWriteStrobe)
      else $error("write flag rose without a strobe");
   strobe_busy_a: assert property (nvWriteStrobe |-> !$past(nvWriteActiveFlag))
      else $error("write started during a write cycle");
   strobe_pulse_a: assert property (nvWriteStrobe |=> !nvWriteStrobe[*8])
      else $error("write strobe repeated");
   busy_length_a: assert property ($fell(nvWriteActiveFlag) |->
      busyCount >= NV_WRITE_CYCLES && busyCount <= NV_WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   lock_cause_a: assert property (age == 7 && !$stable(lockBits) |-> nvWriteStrobe)
      else $error("lock bits changed without a write");
   lock_value_a: assert property (nvWriteStrobe |->
      lockBits[nvWriteAddress[0]] == nvWriteValue &&
      nvWriteAddress inside {5'h10, 5'h11})
      else $error("lock bit or write address wrong");
   supply_ref_a: assert property ($stable(referenceSelectField)[*2] |=>
      supplyReference == {$past(referenceSelectField[3:2]) == 2'h0,
      $past(referenceSelectField[1:0]) == 2'h0})
      else $error("supply reference wrong");
   error_holds_a: assert property (!chipSelectN && !serialDataOut |=>
      chipSelectN || !serialDataOut)
      else $error("data out left the error level");
   cs_release_a: assert property (chipSelectN |->
      !serialDataOutEnable && serialDataOut)
      else $error("link not idle with select released");
   vol_accept_a: assert property (volatileCommandStrobe |->
      volatileCommandCode inside {cbd_pkg::CMD_WRITE, cbd_pkg::CMD_READ} &&
      !(nvWriteActiveFlag && volatileCommandAddress > 5'h0F))
      else $error("volatile command accepted wrongly");
   cover property (nvWriteStrobe && !nvWriteValue);
   cover property (volatileCommandStrobe && nvWriteActiveFlag);
   cover property ($fell(serialDataOut));
endmodule : cbd_chk
`default_nettype wire

/* verification/spi_host_model.sv */
// host controller driving the serial link in mode 0,0
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   output logic serialClock,
   output logic chipSelectN,
   output logic serialDataIn,
   input wire logic serialDataOut,
   input wire logic serialDataOutEnable
);
   logic lastOut;
   // clock idles low outside frames
   initial
   begin
      serialClock = 1'h0;
      chipSelectN = 1'h0;
      serialDataIn = 1'h0;
      lastOut = 1'h0;
      #1 chipSelectN = 1'h1; // rising select clears the link state
   end
   // one select of n bits, msb of bits first; got holds the wire samples, and an undriven slot holds the inverse of the sample before it
   task automatic xfer(input logic [31:0] bits, input int n,
      output logic [31:0] got);
      got = 32'h0;
      #3 chipSelectN = 1'h0;
      for (int i = 0; i < n; i++)
      begin
         serialDataIn = bits[31 - i];
         #16 serialClock = 1'h1;
         lastOut = serialDataOutEnable ? serialDataOut : ~lastOut;
         got = {got[30:0], lastOut};
         #16 serialClock = 1'h0;
      end
      #16 chipSelectN = 1'h1;
      serialDataIn = ~serialDataIn; // released line shows no stale bit
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* verification/config_bit_disable_command_tb.sv */
// self-checking bench of the configuration bit command port
`timescale 1ns/10ps
`default_nettype none
module config_bit_disable_command_tb;
   logic clock, reset, pin;
   logic [1:0] stored, expLock;
   logic [3:0] refSel;
   wire sck, csN, sdi, sdo, sdoEn, flag, nvStb, nvVal, vStb;
   wire [4:0] nvAddr, vAddr;
   wire [1:0] lock, supRef, vCode;
   int bad_count = 0, compares = 0, seed = 32'hBAEA;
   int nvCount = 0, vCount = 0, nvExp = 0, vExp = 0;
   logic [5:0] nvQ[$];
   config_bit_disable_command #(.NV_WRITE_CYCLES(400)) u_dut (
      .clock(clock), .reset(reset), .serialClock(sck), .chipSelectN(csN),
      .serialDataIn(sdi), .highVoltageCommandPin(pin),
      .storedLockBits(stored), .referenceSelectField(refSel),
      .serialDataOut(sdo), .serialDataOutEnable(sdoEn),
      .nvWriteActiveFlag(flag), .nvWriteStrobe(nvStb),
      .nvWriteAddress(nvAddr), .nvWriteValue(nvVal), .lockBits(lock),
      .supplyReference(supRef), .volatileCommandStrobe(vStb),
      .volatileCommandAddress(vAddr), .volatileCommandCode(vCode));
   spi_host_model u_host (.serialClock(sck), .chipSelectN(csN),
      .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutEnable(sdoEn));
   // system clock
   initial
   begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // strobe counters
   always @(posedge clock)
   begin
      nvCount += nvStb;
      vCount += vStb;
   end
   // every store request against the oldest expected one
   always @(negedge clock)
   begin
      if (nvStb === 1'h1)
      begin
         if (nvQ.size() == 0)
            check(nvStb, 1'h0);
         else
            check({nvAddr, nvVal}, nvQ.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task stop_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // one selection: header a,c over n bits; first slot is not driven
   task automatic cmd(input logic hv, input logic [4:0] a,
      input logic [1:0] c, input int n, input logic err, input int nvInc,
      input int vInc);
      logic [31:0] got;
      int m;
      m = (1 << (n - 1)) - 1;
      @(negedge clock);
      pin = hv;
      #100;
      if (nvInc != 0)
         nvQ.push_back({a, c == 2'h2});
      u_host.xfer({a, c, 25'h0}, n, got);
      repeat (10) @(negedge clock);
      nvExp += nvInc;
      vExp += vInc;
      if (nvInc != 0)
         expLock[a[0]] = (c == 2'h2);
      check(got & m, err ? 32'h3F << (n - 7) : m);
      check(nvCount, nvExp);
      check(vCount, vExp);
      check(lock, expLock);
   endtask : cmd
   task automatic waitIdle();
      for (int i = 0; i < 600 && flag !== 1'h0; i++)
         @(negedge clock);
      check(flag, 1'h0);
   endtask : waitIdle
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset = 1'h1;
      pin = 1'h0;
      stored = 2'($random(seed));
      refSel = 4'h0;
      repeat (8) @(negedge clock);
      reset = 1'h0;
      expLock = stored;
      repeat (4) @(negedge clock);
      check(lock, stored);
      for (int i = 0; i < 5; i++)
      begin
         refSel = i ? 4'($random(seed)) : 4'h4;
         repeat (3) @(negedge clock);
         check(supRef, {refSel[3:2] == 2'h0, refSel[1:0] == 2'h0});
      end
      cmd(1'h1, 5'h10, 2'h1, 8, 1'h0, 1, 0);
      check(flag, 1'h1);
      check({nvAddr, nvVal}, {5'h10, 1'h0});
      cmd(1'h0, 5'h0A, 2'h3, 24, 1'h0, 0, 1);
      check({vAddr, vCode}, {5'h0A, 2'h3});
      cmd(1'h0, 5'h10, 2'h0, 24, 1'h0, 0, 0);
      cmd(1'h1, 5'h11, 2'h2, 16, 1'h1, 0, 0);
      waitIdle();
      cmd(1'h0, 5'h11, 2'h2, 8, 1'h1, 0, 0);
      cmd(1'h1, 5'h12, 2'h1, 8, 1'h1, 0, 0);
      cmd(1'h1, 5'h11, 2'h2, 7, 1'h0, 0, 0);
      for (int k = 0; k < 4; k++)
      begin
         cmd(1'h1, {4'h8, k[0]}, k[1] ? 2'h2 : 2'h1, 8, 1'h0, 1, 0);
         waitIdle();
      end
      stop_test();
   end
   // watchdog
   initial
   begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : config_bit_disable_command_tb
bind config_bit_disable_command cbd_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
   u_chk (.clock, .reset, .chipSelectN, .referenceSelectField,
   .serialDataOut, .serialDataOutEnable, .nvWriteActiveFlag, .nvWriteStrobe,
   .nvWriteAddress, .nvWriteValue, .lockBits, .supplyReference,
   .volatileCommandStrobe, .volatileCommandAddress, .volatileCommandCode);
`default_nettype wire
